// >>> src/pulse_gen.sv
// square wave generator with a one-cycle strobe at each falling edge
`timescale 1ns/1ns
module pulse_gen #(
  parameter int unsigned CLK_HZ = ramp_pkg::CLK_HZ,
  parameter int unsigned HZ_W   = 17
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            en,
  input  wire logic [HZ_W-1:0] hz,
  output logic                 wave_q,
  output logic                 fall_q
);
  localparam logic [31:0] HALF = 32'(CLK_HZ / 2);

  if (HALF <= (32'h1 << HZ_W)) begin : g_bad_clk
    $error("pulse_gen: clock too slow for the frequency range");
  end

  logic [31:0] acc_q;
  logic [31:0] sum_w;
  logic        wrap_w;

  // accumulate hz per cycle; two wraps make one period of hz
  assign sum_w  = acc_q + 32'(hz);
  assign wrap_w = sum_w >= HALF;

  always_ff @(posedge clk)
  begin
    if (!rst_b || !en)
    begin
      acc_q  <= 32'h0000_0000;
      wave_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      acc_q  <= wrap_w ? sum_w - HALF : sum_w;
      wave_q <= wrap_w ? ~wave_q : wave_q;
      fall_q <= wrap_w & wave_q;
    end
  end
endmodule // pulse_gen

// >>> src/ramp_pkg.sv
// constants, register map and types of the ramp pulse generator
package ramp_pkg;
  localparam int unsigned CLK_HZ      = 32'h02FA_F080; // 50 MHz
  localparam int unsigned MS_PER_S    = 32'h0000_03E8;
  localparam int unsigned STEP_MS     = 32'h0000_000A;
  localparam int unsigned STEP_CYCLES = CLK_HZ / MS_PER_S * STEP_MS;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STEADY = 8'h04;
  localparam logic [7:0] OFS_START  = 8'h08;
  localparam logic [7:0] OFS_RAMP   = 8'h0C;
  localparam logic [7:0] OFS_PRESET = 8'h10;
  localparam logic [7:0] OFS_ERROR  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  localparam int unsigned CTRL_MODE = 0;
  localparam int unsigned CTRL_REV  = 1;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_DONE   = 1;
  localparam int unsigned ST_RAMP   = 2;
  localparam int unsigned ST_PERR   = 3;

  localparam logic [15:0] RST_STEADY = 16'h0064;
  localparam logic [15:0] RST_START  = 16'h0064;
  localparam logic [15:0] RST_RAMP   = 16'h0064;
  localparam logic [31:0] RST_PRESET = 32'h0098_9680;

  localparam logic [15:0] FREQ_MIN_M0 = 16'h0001;
  localparam logic [15:0] FREQ_MIN_M1 = 16'h0014;
  localparam logic [15:0] FREQ_MAX    = 16'h2710;
  localparam logic [15:0] RAMP_MIN    = 16'h000A;
  localparam logic [15:0] RAMP_MAX    = 16'h2710;
  localparam logic [15:0] RAMP_UNIT   = 16'h000A;
  localparam logic [31:0] PRESET_MIN  = 32'h0000_0001;
  localparam logic [31:0] PRESET_MAX  = 32'h05F5_E100;
  localparam logic [3:0]  MODE1_SCALE = 4'hA;
  localparam logic [7:0]  PULSE_SCALE = 8'h64;

  localparam logic [15:0] ERR_NONE   = 16'h0000;
  localparam logic [15:0] ERR_START  = 16'h0002;
  localparam logic [15:0] ERR_PRESET = 16'h0003;
  localparam logic [15:0] ERR_STEADY = 16'h0004;
  localparam logic [15:0] ERR_RAMP   = 16'h0005;
  localparam logic [15:0] ERR_PULSES = 16'h0008;
  localparam logic [15:0] ERR_ORDER  = 16'h0009;

  localparam logic [1:0] REV_OFF    = 2'h0;
  localparam logic [1:0] REV_SINGLE = 2'h1;
  localparam logic [1:0] REV_DUAL   = 2'h2;

  typedef enum {S_IDLE, S_ACCEL, S_STEADY, S_DECEL, S_TAIL, S_DONE} state_t;
endpackage

// >>> src/ramp_pulse_output.sv
// ramp pulse output block with its apb register file
// How it works
// - run rise checks settings, flags error
// - code 0 ok, 2 bad start frequency
// - code 3 when preset out of range
// - code 4 bad steady frequency
// - code 5 ramp time outside 10..10000 ms
// - code 8 ramp pulses exceed preset
// - code 9 start not below steady
// - pulses while run on, busy meanwhile
// - ramping flag only while frequency changes
// - frequency steps once every 10 ms
// - preset reached: stop, done, block output
// - run off halts output at once
// - new run clears count, restarts
// - settings snapshot at run rise
// - init ignored while run is on
// - single mode: direction pin follows input
// - dual mode: pulse pin chosen by direction
// - dual: first forward, second reverse
// - mode 1 scales frequency by ten
// - block output is done gated by run
`timescale 1ns/1ns
module ramp_pulse_output #(
  parameter int unsigned STEP_CYCLES = ramp_pkg::STEP_CYCLES,
  parameter int unsigned CLK_HZ      = ramp_pkg::CLK_HZ
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RUN_IN,
  input  wire logic        INIT_IN,
  input  wire logic        DIR_IN,
  output logic             FIRST_PULSE,
  output logic             SECOND_PULSE,
  output logic             DIR_OUT,
  output logic             BUSY,
  output logic             DONE,
  output logic             RAMPING,
  output logic             BLOCK_OUT,
  output logic             PROG_ERR
);
  // the frequency drain needs up to FREQ_MAX cycles inside one step
  if (STEP_CYCLES <= 32'(ramp_pkg::FREQ_MAX) + 2) begin : g_bad_step
    $error("ramp_pulse_output: STEP_CYCLES too small");
  end

  function automatic logic freq_ok(input logic [15:0] f, input logic m);
    freq_ok = f >= (m ? ramp_pkg::FREQ_MIN_M1 : ramp_pkg::FREQ_MIN_M0)
              && f <= ramp_pkg::FREQ_MAX;
  endfunction

  // settings written by software
  logic        mode_q;
  logic [1:0]  rev_q;
  logic [15:0] steady_q;
  logic [15:0] start_q;
  logic [15:0] ramp_q;
  logic [31:0] preset_q;
  // snapshot taken at run rise
  logic        s_mode_q;
  logic [1:0]  s_rev_q;
  logic        s_dir_q;
  logic [15:0] s_steady_q;
  logic [15:0] s_start_q;
  logic [15:0] s_steps_q;
  logic [31:0] s_preset_q;
  // run state
  ramp_pkg::state_t state_q;
  ramp_pkg::state_t state_d;
  logic        run_q;
  logic [15:0] err_q;
  logic        perr_q;
  logic [31:0] cnt_q;
  logic [31:0] up_q;
  logic [31:0] tick_q;
  logic [15:0] stepn_q;
  logic [15:0] frac_q;
  logic [15:0] freq_q;
  logic        wave;
  logic        fall;

  // apb decode
  wire setup_w  = PSEL & ~PENABLE;
  wire wr_w     = PSEL & PENABLE & PREADY & PWRITE;
  wire sel_ctrl = PADDR == ramp_pkg::OFS_CTRL;
  wire sel_stdy = PADDR == ramp_pkg::OFS_STEADY;
  wire sel_strt = PADDR == ramp_pkg::OFS_START;
  wire sel_ramp = PADDR == ramp_pkg::OFS_RAMP;
  wire sel_pre  = PADDR == ramp_pkg::OFS_PRESET;
  wire sel_err  = PADDR == ramp_pkg::OFS_ERROR;
  wire sel_st   = PADDR == ramp_pkg::OFS_STATUS;
  wire mapped_w = sel_ctrl | sel_stdy | sel_strt | sel_ramp | sel_pre
                  | sel_err | sel_st;
  wire [3:0] status_w = {perr_q, RAMPING, DONE, BUSY};
  wire [31:0] rdata_w =
      sel_ctrl ? {29'h0, rev_q, mode_q} :
      sel_stdy ? {16'h0, steady_q} :
      sel_strt ? {16'h0, start_q} :
      sel_ramp ? {16'h0, ramp_q} :
      sel_pre  ? preset_q :
      sel_err  ? {16'h0, err_q} :
      sel_st   ? {28'h0, status_w} : 32'h0000_0000;

  // setting check on the live registers, the same values the snapshot takes
  wire        rise_w   = RUN_IN & ~run_q;
  wire [15:0] steps_w  = ramp_q / ramp_pkg::RAMP_UNIT;
  wire [16:0] fsum_w   = {1'b0, start_q} + {1'b0, steady_q};
  wire [47:0] rpulse_w = 48'(fsum_w) * 48'(mode_q ? ramp_pkg::MODE1_SCALE
                         : 4'h1) * 48'(steps_w);
  wire [47:0] plimit_w = 48'(preset_q) * 48'(ramp_pkg::PULSE_SCALE);
  wire [15:0] err_w =
      !freq_ok(start_q, mode_q) ? ramp_pkg::ERR_START :
      (preset_q < ramp_pkg::PRESET_MIN ||
       preset_q > ramp_pkg::PRESET_MAX) ? ramp_pkg::ERR_PRESET :
      !freq_ok(steady_q, mode_q) ? ramp_pkg::ERR_STEADY :
      (ramp_q < ramp_pkg::RAMP_MIN ||
       ramp_q > ramp_pkg::RAMP_MAX) ? ramp_pkg::ERR_RAMP :
      (start_q >= steady_q) ? ramp_pkg::ERR_ORDER :
      (rpulse_w > plimit_w) ? ramp_pkg::ERR_PULSES :
      ramp_pkg::ERR_NONE;
  wire go_w = rise_w && err_w == ramp_pkg::ERR_NONE;

  // ramp arithmetic on the snapshot
  wire        active_w = state_q inside {ramp_pkg::S_ACCEL,
                         ramp_pkg::S_STEADY, ramp_pkg::S_DECEL,
                         ramp_pkg::S_TAIL};
  wire        tick_w   = active_w && tick_q == 32'(STEP_CYCLES - 1);
  wire        slope_w  = state_q inside {ramp_pkg::S_ACCEL,
                         ramp_pkg::S_DECEL};
  wire [15:0] diff_w   = s_steady_q - s_start_q;
  wire [15:0] frac_w   = (slope_w && tick_w) ? frac_q + diff_w : frac_q;
  wire        drain_w  = slope_w && frac_w >= s_steps_q;
  wire        sdone_w  = stepn_q == s_steps_q && frac_q < s_steps_q;
  wire [31:0] remain_w = s_preset_q - cnt_q;
  wire        last_w   = fall && cnt_q + 32'h1 == s_preset_q;
  wire [16:0] hz_w     = s_mode_q ? 17'(freq_q) * 17'(ramp_pkg::MODE1_SCALE)
                         : 17'(freq_q);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ramp_pkg::S_ACCEL:
        if (remain_w <= up_q) state_d = ramp_pkg::S_DECEL;
        else if (sdone_w) state_d = ramp_pkg::S_STEADY;
      ramp_pkg::S_STEADY:
        if (remain_w <= up_q) state_d = ramp_pkg::S_DECEL;
      ramp_pkg::S_DECEL:
        if (sdone_w) state_d = ramp_pkg::S_TAIL;
      default: ;
    endcase
    if (active_w && last_w) state_d = ramp_pkg::S_DONE;
    if (go_w) state_d = ramp_pkg::S_ACCEL;
    else if (rise_w) state_d = ramp_pkg::S_IDLE;
    if (!RUN_IN && state_d != ramp_pkg::S_DONE)
      state_d = ramp_pkg::S_IDLE;
  end

  wire busy_d = state_d inside {ramp_pkg::S_ACCEL, ramp_pkg::S_STEADY,
                ramp_pkg::S_DECEL, ramp_pkg::S_TAIL};
  wire ramp_d = state_d inside {ramp_pkg::S_ACCEL,
                ramp_pkg::S_DECEL};
  wire done_d = state_d == ramp_pkg::S_DONE;
  wire dual_w = s_rev_q == ramp_pkg::REV_DUAL;
  wire init_w = INIT_IN & ~RUN_IN;

  pulse_gen #(
    .CLK_HZ (CLK_HZ),
    .HZ_W   (17)
  ) u_gen (
    .clk    (REF_CLK),
    .rst_b  (RST_B),
    .en     (active_w && RUN_IN),
    .hz     (hz_w),
    .wave_q (wave),
    .fall_q (fall)
  );

  // software settings; init restores defaults only while run is off
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B || init_w)
    begin
      mode_q   <= 1'b0;
      rev_q    <= ramp_pkg::REV_OFF;
      steady_q <= ramp_pkg::RST_STEADY;
      start_q  <= ramp_pkg::RST_START;
      ramp_q   <= ramp_pkg::RST_RAMP;
      preset_q <= ramp_pkg::RST_PRESET;
    end
    else if (wr_w)
    begin
      if (sel_ctrl) mode_q <= PWDATA[ramp_pkg::CTRL_MODE];
      if (sel_ctrl) rev_q <= PWDATA[ramp_pkg::CTRL_REV +: 2];
      if (sel_stdy) steady_q <= PWDATA[15:0];
      if (sel_strt) start_q <= PWDATA[15:0];
      if (sel_ramp) ramp_q <= PWDATA[15:0];
      if (sel_pre) preset_q <= PWDATA;
    end
  end

  // snapshot; later writes wait for the next rise
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      s_mode_q   <= 1'b0;
      s_rev_q    <= ramp_pkg::REV_OFF;
      s_dir_q    <= 1'b0;
      s_steady_q <= ramp_pkg::RST_STEADY;
      s_start_q  <= ramp_pkg::RST_START;
      s_steps_q  <= 16'h0001;
      s_preset_q <= ramp_pkg::RST_PRESET;
    end
    else if (go_w)
    begin
      s_mode_q   <= mode_q;
      s_rev_q    <= rev_q;
      s_dir_q    <= DIR_IN;
      s_steady_q <= steady_q;
      s_start_q  <= start_q;
      s_steps_q  <= steps_w;
      s_preset_q <= preset_q;
    end
  end

  // pulse count, step timer and frequency walk
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B || go_w)
    begin
      state_q <= go_w ? ramp_pkg::S_ACCEL : ramp_pkg::S_IDLE;
      cnt_q   <= 32'h0000_0000;
      up_q    <= 32'h0000_0000;
      tick_q  <= 32'h0000_0000;
      stepn_q <= 16'h0000;
      frac_q  <= 16'h0000;
      freq_q  <= go_w ? start_q : 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (active_w && fall) ? cnt_q + 32'h1 : cnt_q;
      up_q    <= (state_q == ramp_pkg::S_ACCEL && fall) ? up_q + 32'h1 : up_q;
      tick_q  <= (!active_w || tick_w) ? 32'h0000_0000 : tick_q + 32'h1;
      stepn_q <= state_d != state_q ? 16'h0000 :
                 (slope_w && tick_w && stepn_q != s_steps_q) ?
                 stepn_q + 16'h1 : stepn_q;
      frac_q  <= state_d != state_q ? 16'h0000 :
                 drain_w ? frac_w - s_steps_q : frac_w;
      freq_q  <= !drain_w ? freq_q :
                 state_q == ramp_pkg::S_ACCEL ? freq_q + 16'h1 :
                 freq_q - 16'h1;
    end
  end

  // registered outputs and status; a program error set beats its clear
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      FIRST_PULSE  <= 1'b0;
      SECOND_PULSE <= 1'b0;
      DIR_OUT      <= 1'b0;
      BUSY         <= 1'b0;
      DONE         <= 1'b0;
      RAMPING      <= 1'b0;
      BLOCK_OUT    <= 1'b0;
      PROG_ERR     <= 1'b0;
      PRDATA       <= 32'h0000_0000;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      err_q        <= ramp_pkg::ERR_NONE;
      perr_q       <= 1'b0;
      run_q        <= 1'b0;
    end
    else
    begin
      FIRST_PULSE  <= wave & RUN_IN & ~(dual_w & s_dir_q);
      SECOND_PULSE <= wave & RUN_IN & dual_w & s_dir_q;
      DIR_OUT      <= (s_rev_q == ramp_pkg::REV_SINGLE) & DIR_IN;
      BUSY         <= busy_d;
      DONE         <= done_d;
      RAMPING      <= ramp_d;
      BLOCK_OUT    <= done_d & RUN_IN;
      PROG_ERR     <= (rise_w && err_w != ramp_pkg::ERR_NONE) || perr_q;
      PRDATA       <= setup_w ? rdata_w : PRDATA;
      PREADY       <= setup_w;
      PSLVERR      <= setup_w & ~mapped_w;
      run_q        <= RUN_IN;
      err_q        <= rise_w ? err_w : err_q;
      perr_q       <= (rise_w && err_w != ramp_pkg::ERR_NONE) ||
                      (perr_q && !(wr_w && sel_st &&
                      PWDATA[ramp_pkg::ST_PERR]));
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  err_store_a: assert property (rise_w |=> err_q == $past(err_w))
    else $error("error code not stored on run rise");
  code_two_a: assert property (rise_w && !freq_ok(start_q, mode_q)
    |=> err_q == ramp_pkg::ERR_START && PROG_ERR)
    else $error("bad start frequency not reported");
  bad_start_a: assert property (rise_w && err_w != ramp_pkg::ERR_NONE
    |=> !BUSY [*2])
    else $error("busy after failed check");
  halt_now_a: assert property (!RUN_IN |=> !BUSY && !BLOCK_OUT)
    else $error("output not halted with run off");
  finish_a: assert property (BUSY && last_w && RUN_IN && !rise_w
    |=> DONE && !BUSY && BLOCK_OUT)
    else $error("preset reached but not done");
  flat_a: assert property (state_q == ramp_pkg::S_STEADY && !go_w
    |=> $stable(freq_q))
    else $error("frequency moved while steady");
  slope_a: assert property ($changed(freq_q) && !$past(go_w)
    |-> $past(slope_w))
    else $error("frequency changed outside a ramp");
  hold_set_a: assert property (BUSY && !rise_w |=> $stable(s_preset_q))
    else $error("snapshot changed during output");
  init_ign_a: assert property (RUN_IN && INIT_IN && !wr_w
    |=> $stable(preset_q))
    else $error("init acted while run on");
  rev_only_a: assert property (dual_w && !s_dir_q |=> !SECOND_PULSE)
    else $error("reverse pin pulsed going forward");

  run_done_c: cover property (BUSY ##1 DONE);
  run_err_c: cover property (rise_w && err_w == ramp_pkg::ERR_PULSES);
  run_halt_c: cover property (BUSY ##1 !RUN_IN);
endmodule // ramp_pulse_output

// >>> testbench/drive_model.sv
// pulse-input motor drive model that counts steps on each channel
`timescale 1ns/1ns
module drive_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clr,
  input  wire logic        pulse_a,
  input  wire logic        pulse_b,
  output logic      [31:0] a_cnt,
  output logic      [31:0] b_cnt
);
  logic a_q;
  logic b_q;

  // a step is taken on each rising edge, as an opto input would see it
  always_ff @(posedge clk)
  begin
    a_q <= pulse_a;
    b_q <= pulse_b;
    if (!rst_b || clr)
    begin
      a_cnt <= 32'h0000_0000;
      b_cnt <= 32'h0000_0000;
    end
    else
    begin
      a_cnt <= a_cnt + {31'h0000_0000, pulse_a & ~a_q};
      b_cnt <= b_cnt + {31'h0000_0000, pulse_b & ~b_q};
    end
  end
endmodule // drive_model

// >>> testbench/ramp_pulse_output_bench.sv
// self-checking bench for the ramp pulse output block
`timescale 1ns/1ns
module ramp_pulse_output_bench;
  localparam int unsigned STEP = 32'h0000_2742;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        run     = 1'b0;
  logic        init    = 1'b0;
  logic        dir     = 1'b0;
  logic        clr     = 1'b0;
  logic [31:0] prdata, rd, a_cnt, b_cnt;
  logic        pready, pslverr, err, pa, pb, dout;
  logic        busy, done, ramping, blk, perr;
  int          fails       = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // clock scaled down so that pulse periods stay short in simulation
  ramp_pulse_output #(.STEP_CYCLES(STEP), .CLK_HZ(32'h000F_4240)) uut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RUN_IN(run), .INIT_IN(init),
    .DIR_IN(dir), .FIRST_PULSE(pa), .SECOND_PULSE(pb), .DIR_OUT(dout),
    .BUSY(busy), .DONE(done), .RAMPING(ramping), .BLOCK_OUT(blk),
    .PROG_ERR(perr)
  );
  drive_model far (.clk(ref_clk), .rst_b(rst_b), .clr(clr), .pulse_a(pa),
    .pulse_b(pb), .a_cnt(a_cnt), .b_cnt(b_cnt));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up(input string n);
    fails++;
    $display("MISMATCH %s expected done seen timeout", n);
    close_out();
  endtask

  task automatic check_val(input string n, input logic [31:0] e,
                           input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      give_up("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_check(input string n, input logic [7:0] a,
                          input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check_val(n, e, rd);
  endtask

  function automatic logic [15:0] exp_code(input logic m,
    input logic [15:0] sf, input logic [15:0] st, input logic [15:0] rm,
    input logic [31:0] pr);
    logic [15:0]     lo;
    longint unsigned rp;
    lo = m ? 16'h0014 : 16'h0001;
    rp = longint'(32'(st) + sf) * (m ? 10 : 1) * (rm / 10);
    if (st < lo || st > 16'h2710) return 16'h0002;
    if (pr < 32'h0000_0001 || pr > 32'h05F5_E100) return 16'h0003;
    if (sf < lo || sf > 16'h2710) return 16'h0004;
    if (rm < 16'h000A || rm > 16'h2710) return 16'h0005;
    if (st >= sf) return 16'h0009;
    if (rp > longint'(pr) * 100) return 16'h0008;
    return 16'h0000;
  endfunction

  task automatic run_case(input logic m, input logic [15:0] sf,
    input logic [15:0] st, input logic [15:0] rm, input logic [31:0] pr);
    logic [15:0] e;
    e = exp_code(m, sf, st, rm, pr);
    apb(1'b1, ramp_pkg::OFS_CTRL, {31'h0000_0000, m});
    apb(1'b1, ramp_pkg::OFS_STEADY, {16'h0000, sf});
    apb(1'b1, ramp_pkg::OFS_START, {16'h0000, st});
    apb(1'b1, ramp_pkg::OFS_RAMP, {16'h0000, rm});
    apb(1'b1, ramp_pkg::OFS_PRESET, pr);
    @(posedge ref_clk);
    run <= 1'b1;
    tick(3);
    @(negedge ref_clk);
    check_bit("prog error", e != 16'h0000, perr);
    check_bit("busy", e == 16'h0000, busy);
    rd_check("error code", ramp_pkg::OFS_ERROR, {16'h0000, e});
    @(posedge ref_clk);
    run <= 1'b0;
    apb(1'b1, ramp_pkg::OFS_STATUS, 32'h0000_0008);
  endtask

  initial
  begin
    logic        prev;
    logic        rp;
    logic [31:0] snap;
    int          n;
    int          m;
    int          first_fall;
    int          rises;
    int          gaps;
    void'($urandom(32'hb585_3bd5));
    tick(10);
    rst_b <= 1'b1;
    rd_check("ctrl", ramp_pkg::OFS_CTRL, 32'h0000_0000);
    rd_check("steady", ramp_pkg::OFS_STEADY, 32'h0000_0064);
    rd_check("start", ramp_pkg::OFS_START, 32'h0000_0064);
    rd_check("ramp", ramp_pkg::OFS_RAMP, 32'h0000_0064);
    rd_check("preset", ramp_pkg::OFS_PRESET, 32'h0098_9680);
    rd_check("error", ramp_pkg::OFS_ERROR, 32'h0000_0000);
    rd_check("status", ramp_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check_bit("slverr", 1'b1, err);
    check_val("unmapped", 32'h0000_0000, rd);
    apb(1'b1, ramp_pkg::OFS_ERROR, 32'h0000_00FF);
    rd_check("error ro", ramp_pkg::OFS_ERROR, 32'h0000_0000);
    end_test("reset values");
    run_case(1'b0, 16'h0064, 16'h0064, 16'h0064, 32'h0098_9680);
    tick(2);
    @(negedge ref_clk);
    check_bit("prog error clear", 1'b0, perr);
    run_case(1'b0, 16'h0064, 16'h0000, 16'h0064, 32'h0000_03E8);
    run_case(1'b0, 16'h0064, 16'h2711, 16'h0064, 32'h0000_03E8);
    run_case(1'b1, 16'h0064, 16'h0013, 16'h0064, 32'h0000_03E8);
    run_case(1'b1, 16'h0064, 16'h0014, 16'h0064, 32'h0000_03E8);
    run_case(1'b0, 16'h0064, 16'h0032, 16'h0064, 32'h0000_0000);
    run_case(1'b0, 16'h0064, 16'h0032, 16'h0064, 32'h05F5_E101);
    run_case(1'b0, 16'h0064, 16'h0032, 16'h0064, 32'h05F5_E100);
    run_case(1'b0, 16'h0000, 16'h0001, 16'h0064, 32'h0000_03E8);
    run_case(1'b1, 16'h0013, 16'h0014, 16'h0064, 32'h0000_03E8);
    run_case(1'b0, 16'h0064, 16'h0032, 16'h0009, 32'h0000_03E8);
    run_case(1'b0, 16'h0064, 16'h0032, 16'h2711, 32'h0000_03E8);
    run_case(1'b0, 16'h0032, 16'h0064, 16'h0064, 32'h0000_03E8);
    run_case(1'b0, 16'h2710, 16'h03E8, 16'h000A, 32'h0000_006D);
    run_case(1'b0, 16'h2710, 16'h03E8, 16'h000A, 32'h0000_006E);
    for (int i = 0; i < 10; i++)
      run_case(1'($urandom), 16'($urandom_range(0, 32'h0000_2EE0)),
        16'($urandom_range(0, 32'h0000_2EE0)),
        16'($urandom_range(0, 32'h0000_2AF8)),
        $urandom_range(0, 32'h068E_7780));
    end_test("settings check");
    run_case(1'b0, 16'h07D0, 16'h03E8, 16'h000A, 32'h0000_003C);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    run <= 1'b1;
    n = cyc;
    tick(2000);
    @(negedge ref_clk);
    check_bit("ramping accel", 1'b1, ramping);
    apb(1'b1, ramp_pkg::OFS_PRESET, 32'h0000_0005);
    @(posedge ref_clk);
    init <= 1'b1;
    tick(3);
    init <= 1'b0;
    prev = 1'b1;
    first_fall = 0;
    rises = 0;
    gaps = 0;
    m = 0;
    while (done !== 1'b1 && m < 60000)
    begin
      @(negedge ref_clk);
      m++;
      if (prev && !ramping && first_fall == 0)
        first_fall = cyc - n;
      if (!prev && ramping)
        rises++;
      if (busy !== 1'b1 && done !== 1'b1)
        gaps++;
      prev = ramping;
    end
    if (done !== 1'b1)
      give_up("done");
    check_val("pulses", 32'h0000_003C, a_cnt);
    check_val("second pulses", 32'h0000_0000, b_cnt);
    check_bit("busy end", 1'b0, busy);
    check_bit("block out", 1'b1, blk);
    check_bit("ramping end", 1'b0, ramping);
    check_val("decel phases", 32'h0000_0001, rises);
    check_val("busy gaps", 32'h0000_0000, gaps);
    check_bit("step time", 1'b1,
      first_fall >= STEP - 2 && first_fall <= STEP + 1002);
    rd_check("start kept", ramp_pkg::OFS_START, 32'h0000_03E8);
    @(posedge ref_clk);
    run <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    check_bit("block out off", 1'b0, blk);
    check_bit("done held", 1'b1, done);
    @(posedge ref_clk);
    run <= 1'b1;
    rd_check("late preset", ramp_pkg::OFS_ERROR, 32'h0000_0008);
    @(posedge ref_clk);
    run <= 1'b0;
    apb(1'b1, ramp_pkg::OFS_PRESET, 32'h0000_0078);
    apb(1'b1, ramp_pkg::OFS_STATUS, 32'h0000_0008);
    end_test("full run");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      clr <= 1'b1;
      run <= 1'b1;
      tick(3);
      clr <= 1'b0;
      @(negedge ref_clk);
      check_bit("restart busy", 1'b1, busy);
      check_bit("restart ramp", 1'b1, ramping);
      n = 0;
      while (a_cnt < 3 && n < 10000)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (a_cnt < 3)
        give_up("pulses");
      run <= 1'b0;
      tick(2);
      @(negedge ref_clk);
      check_bit("halt busy", 1'b0, busy);
      snap = a_cnt;
      tick(3000);
      check_val("halted pulses", snap, a_cnt);
    end
    end_test("halt and restart");
    apb(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0004);
    for (int d = 0; d < 2; d++)
    begin
      @(posedge ref_clk);
      dir <= 1'(d);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      run <= 1'b1;
      tick(4000);
      run <= 1'b0;
      tick(3);
      check_bit("first channel", d == 0, a_cnt != 0);
      check_bit("second channel", d == 1, b_cnt != 0);
    end
    end_test("dual pulse");
    apb(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0002);
    @(posedge ref_clk);
    run <= 1'b1;
    tick(1);
    prev = dir;
    repeat (20)
    begin
      @(posedge ref_clk);
      rp = 1'($urandom);
      dir <= rp;
      @(negedge ref_clk);
      check_bit("direction out", prev, dout);
      prev = rp;
    end
    @(posedge ref_clk);
    run <= 1'b0;
    end_test("single pulse");
    tick(2);
    init <= 1'b1;
    tick(3);
    init <= 1'b0;
    rd_check("init start", ramp_pkg::OFS_START, 32'h0000_0064);
    rd_check("init ctrl", ramp_pkg::OFS_CTRL, 32'h0000_0000);
    end_test("init");
    close_out();
  end
endmodule // ramp_pulse_output_bench
